/* File: verilog/adc_and_temp_sense_control.sv */
// Converter control: register file on Wishbone, conversion clock, SAR sequencer, sensor bits.
// Assumes an external comparator and RC oscillator arrive asynchronously; sleep comes on clk.
`timescale 1ns/100ps
`include "adc_params.svh"

module adc_and_temp_sense_control (
    input wire logic clk,
    input wire logic rst,
    input wire adc_pkg::wb_req_t wb_req,
    output adc_pkg::wb_rsp_t wb_rsp,
    input wire logic comparator_pin,
    input wire logic internal_rc_conv_clock,
    input wire logic cpu_sleep,
    output adc_pkg::analog_ctl_t analog_ctl,
    output logic wake_request,
    output logic take_isr
);
    import adc_pkg::*;

    typedef struct packed {
        conv_state_t state;
        logic [4:0] channel;
        logic go;
        logic on;
        logic justify;
        logic [2:0] clk_sel;
        logic [1:0] pref;
        logic [7:0] ref_ctl;
        logic done_flag;
        logic irq_en;
        logic global_en;
        logic periph_en;
        logic [7:0] res_hi;
        logic [7:0] res_lo;
        logic [9:0] trial;
        logic [3:0] bit_idx;
        logic [4:0] halves;
        logic [5:0] div_cnt;
        logic [2:0] cmp_sync;
        logic cmp;
        logic [2:0] rc_sync;
        logic rc;
        logic parked;
        logic wake;
        logic isr;
        wb_rsp_t rsp;
        analog_ctl_t ana;
    } ctl_state_t;

    ctl_state_t st;
    ctl_state_t n;
    logic wr;
    logic start;
    logic abort;
    logic tick;
    logic finish;
    logic rc_edge;
    logic [10:0] conv_len;

    // System clock cycles in half a conversion clock period.
    function automatic logic [5:0] half_len(input logic [2:0] sel);
        case (sel)
            3'b000: half_len = 6'h01;
            3'b100: half_len = 6'h02;
            3'b001: half_len = 6'h04;
            3'b101: half_len = 6'h08;
            3'b010: half_len = 6'h10;
            3'b110: half_len = 6'h20;
            default: half_len = 6'h01;
        endcase
    endfunction

    // Route decode: {connected, temperature indicator, fixed reference buffer}.
    function automatic logic [2:0] chan_route(input logic [4:0] code);
        chan_route = 3'h0;
        if (code < 5'h08) begin
            chan_route = 3'h4;
        end else if (code == `CH_TEMP) begin
            chan_route = 3'h6;
        end else if (code == `CH_DAC) begin
            chan_route = 3'h4;
        end else if (code == `CH_FIXED_REF) begin
            chan_route = 3'h5;
        end
    endfunction

    // Aborted result: bits not yet resolved copy the last resolved bit.
    function automatic logic [9:0] partial(input logic [9:0] t, input logic [4:0] h);
        logic [9:0] r;
        int d;
        r = t;
        d = (h >= 5'h03) ? (int'(h) - 1) / 2 : 0;
        for (int i = 0; i < 10; i++) begin
            if (i < 10 - d) begin
                r[i] = (d == 0) ? 1'b0 : t[10 - d];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] place(input logic [9:0] v, input logic right);
        return right ? {6'h00, v} : {v, 6'h00};
    endfunction

    always_comb begin
        logic [4:0] nh;
        logic [15:0] res;
        logic [31:0] rdata;
        logic [2:0] route;
        nh = 5'h00;
        res = 16'h0000;
        rdata = 32'h0000_0000;
        route = 3'h0;
        n = st;
        n.wake = 1'b0;
        n.isr = 1'b0;
        start = 1'b0;
        abort = 1'b0;
        finish = 1'b0;

        n.cmp_sync = {st.cmp_sync[1:0], comparator_pin};
        if (st.cmp_sync[1] == st.cmp_sync[2]) begin
            n.cmp = st.cmp_sync[2];
        end
        n.rc_sync = {st.rc_sync[1:0], internal_rc_conv_clock};
        rc_edge = (st.rc_sync[1] == st.rc_sync[2]) && (st.rc_sync[2] != st.rc);
        if (rc_edge) begin
            n.rc = st.rc_sync[2];
        end

        wr = wb_req.cyc && wb_req.stb && wb_req.we && !st.rsp.ack && wb_req.sel[0];
        n.rsp.ack = wb_req.cyc && wb_req.stb && !st.rsp.ack;
        if (wb_req.adr == `OFS_CONTROL_0) begin
            rdata[7:0] = {1'b0, st.channel, st.go, st.on};
        end else if (wb_req.adr == `OFS_CONTROL_1) begin
            rdata[7:0] = {st.justify, st.clk_sel, 2'b00, st.pref};
        end else if (wb_req.adr == `OFS_RESULT_HIGH) begin
            rdata[7:0] = st.res_hi;
        end else if (wb_req.adr == `OFS_RESULT_LOW) begin
            rdata[7:0] = st.res_lo;
        end else if (wb_req.adr == `OFS_REF_SENSOR) begin
            rdata[7:0] = st.ref_ctl;
        end else if (wb_req.adr == `OFS_FLAG_REG_1) begin
            rdata[0] = st.done_flag;
        end else if (wb_req.adr == `OFS_ENABLE_REG_1) begin
            rdata[0] = st.irq_en;
        end else if (wb_req.adr == `OFS_IRQ_CONTROL) begin
            rdata[7:6] = {st.global_en, st.periph_en};
        end
        n.rsp.dat = (wb_req.cyc && wb_req.stb && !st.rsp.ack && !wb_req.we) ? rdata : 32'h0000_0000;

        if (wr) begin
            if (wb_req.adr == `OFS_CONTROL_0) begin
                n.channel = wb_req.dat[`CH_LSB +: 5];
                n.on = wb_req.dat[`ON_BIT];
                if (wb_req.dat[`GO_BIT] && wb_req.dat[`ON_BIT] && st.state == IDLE && !st.parked) begin
                    start = 1'b1;
                end
                if ((!wb_req.dat[`GO_BIT] || !wb_req.dat[`ON_BIT]) && st.state == CONVERT) begin
                    abort = 1'b1;
                end
            end else if (wb_req.adr == `OFS_CONTROL_1) begin
                n.justify = wb_req.dat[`JUSTIFY_BIT];
                n.clk_sel = wb_req.dat[`CLKSEL_LSB +: 3];
                n.pref = wb_req.dat[1:0];
            end else if (wb_req.adr == `OFS_REF_SENSOR) begin
                n.ref_ctl = wb_req.dat[7:0];
                n.ref_ctl[`FVR_RDY_BIT] = wb_req.dat[`FVR_EN_BIT];
            end else if (wb_req.adr == `OFS_FLAG_REG_1) begin
                n.done_flag = wb_req.dat[0];
            end else if (wb_req.adr == `OFS_ENABLE_REG_1) begin
                n.irq_en = wb_req.dat[0];
            end else if (wb_req.adr == `OFS_IRQ_CONTROL) begin
                n.global_en = wb_req.dat[`GLOBAL_EN_BIT];
                n.periph_en = wb_req.dat[`PERIPH_EN_BIT];
            end
        end

        // Divided clocks count system cycles, so they scale with it; the RC clock does not.
        if (st.clk_sel[1:0] == 2'b11) begin
            tick = rc_edge;
        end else begin
            tick = st.div_cnt == half_len(st.clk_sel) - 6'h01;
        end

        if (!cpu_sleep) begin
            n.parked = 1'b0;
        end
        if (start) begin
            n.state = CONVERT;
            n.go = 1'b1;
            n.halves = 5'h00;
            n.div_cnt = 6'h00;
            n.trial = `TRIAL_START;
            n.bit_idx = 4'h9;
        end else if (st.state == CONVERT) begin
            if (abort) begin
                res = place(partial(st.trial, st.halves), st.justify);
                n.res_hi = res[15:8];
                n.res_lo = res[7:0];
                n.go = 1'b0;
                n.state = IDLE;
            end else if (cpu_sleep && st.clk_sel[1:0] != 2'b11) begin
                n.go = 1'b0;
                n.state = IDLE;
                n.parked = 1'b1;
            end else begin
                n.div_cnt = tick ? 6'h00 : st.div_cnt + 6'h01;
                if (tick) begin
                    nh = st.halves + 5'h01;
                    n.halves = nh;
                    // Each odd half period from the third to the 21st resolves one bit, MSB first.
                    if (nh[0] && nh >= 5'h03 && nh <= `LAST_DECIDE) begin
                        n.trial[st.bit_idx] = st.cmp;
                        if (st.bit_idx != 4'h0) begin
                            n.trial[st.bit_idx - 4'h1] = 1'b1;
                            n.bit_idx = st.bit_idx - 4'h1;
                        end
                    end
                    if (nh == `HALF_PERIODS) begin
                        finish = 1'b1;
                        res = place(st.trial, st.justify);
                        n.res_hi = res[15:8];
                        n.res_lo = res[7:0];
                        n.go = 1'b0;
                        n.state = IDLE;
                        n.wake = cpu_sleep && st.irq_en;
                        n.isr = cpu_sleep && st.irq_en && st.global_en && st.periph_en;
                        n.parked = cpu_sleep && !st.irq_en;
                    end
                end
            end
        end
        // A completion in the cycle of a software clear still leaves the flag set.
        if (finish) begin
            n.done_flag = 1'b1;
        end

        route = chan_route(n.channel);
        n.ana.channel = n.channel;
        n.ana.channel_valid = route[2];
        n.ana.temp_route = route[1];
        n.ana.fixed_ref_route = route[0];
        n.ana.ref_pin_select = n.pref == `PREF_PIN;
        n.ana.sample_hold = n.state == IDLE && n.on && !n.parked;
        n.ana.trial_code = n.trial;
        n.ana.converter_active = n.on && !n.parked;
        n.ana.temp_sensor_enable = n.ref_ctl[`SENSOR_EN_BIT];
        n.ana.temp_sensor_range = n.ref_ctl[`SENSOR_RANGE_BIT];
        n.ana.fixed_reference_enable = n.ref_ctl[`FVR_EN_BIT];
        n.ana.comparator_ref_gain = n.ref_ctl[3:2];
        n.ana.converter_ref_gain = n.ref_ctl[1:0];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= n;
        end
    end

    assign wb_rsp = st.rsp;
    assign analog_ctl = st.ana;
    assign wake_request = st.wake;
    assign take_isr = st.isr;

    // Cycles spent converting, read only by the checks below.
    always_ff @(posedge clk) begin
        if (rst || start) begin
            conv_len <= 11'h000;
        end else if (st.state == CONVERT) begin
            conv_len <= conv_len + 11'h001;
        end
    end

    flag_on_done_a: assert property (@(posedge clk) disable iff (rst)
        finish |=> st.done_flag)
        else $error("Done flag not set after conversion end.");

    done_clears_busy_a: assert property (@(posedge clk) disable iff (rst)
        finish |=> !st.go && st.state == IDLE)
        else $error("Busy bit still set after completion.");

    right_justify_a: assert property (@(posedge clk) disable iff (rst)
        finish && st.justify |=> st.res_hi[7:2] == 6'h00 && st.res_lo == $past(st.trial[7:0]))
        else $error("Right justified result misplaced.");

    left_justify_a: assert property (@(posedge clk) disable iff (rst)
        finish && !st.justify |=> st.res_lo[5:0] == 6'h00 && st.res_hi == $past(st.trial[9:2]))
        else $error("Left justified result misplaced.");

    msb_first_a: assert property (@(posedge clk) disable iff (rst)
        start |=> st.trial == 10'h200 && st.bit_idx == 4'h9 && st.div_cnt == 6'h00)
        else $error("Conversion did not begin with the top bit.");

    conv_length_a: assert property (@(posedge clk) disable iff (rst)
        finish && st.clk_sel[1:0] != 2'b11 |-> conv_len == {5'h00, half_len(st.clk_sel)} * 11'd23 - 11'd1)
        else $error("Conversion length is not 11.5 clock periods.");

    sleep_abort_a: assert property (@(posedge clk) disable iff (rst)
        cpu_sleep && st.state == CONVERT && st.clk_sel[1:0] != 2'b11 && !abort |=>
        st.state == IDLE && st.parked && !analog_ctl.converter_active)
        else $error("Conversion kept running in sleep without RC clock.");

    wake_on_done_a: assert property (@(posedge clk) disable iff (rst)
        finish && cpu_sleep && st.irq_en |=> wake_request ##1 !wake_request)
        else $error("No single wake pulse on enabled completion.");

    isr_gate_a: assert property (@(posedge clk) disable iff (rst)
        wake_request |-> take_isr == ($past(st.global_en) && $past(st.periph_en)))
        else $error("Service routine entry does not follow enables.");

    sensor_bits_a: assert property (@(posedge clk) disable iff (rst)
        analog_ctl.temp_sensor_enable == st.ref_ctl[5] && analog_ctl.temp_sensor_range == st.ref_ctl[4])
        else $error("Sensor enable or range does not follow its bits.");

    temp_channel_a: assert property (@(posedge clk) disable iff (rst)
        analog_ctl.temp_route == (st.channel == 5'h1D))
        else $error("Channel routing wrong.");

    unused_code_a: assert property (@(posedge clk) disable iff (rst)
        st.channel >= 5'h08 && st.channel <= 5'h1C |-> !analog_ctl.channel_valid)
        else $error("Reserved channel code connected.");

    fixed_route_a: assert property (@(posedge clk) disable iff (rst)
        analog_ctl.fixed_ref_route == (st.channel == `CH_FIXED_REF))
        else $error("Reference buffer routing wrong.");

    flag_kept_a: assert property (@(posedge clk) disable iff (rst)
        st.done_flag && !(wr && wb_req.adr == `OFS_FLAG_REG_1) |=> st.done_flag)
        else $error("Done flag cleared without a software write.");

    rc_sleep_runs_a: assert property (@(posedge clk) disable iff (rst)
        cpu_sleep && st.state == CONVERT && st.clk_sel[1:0] == 2'b11 && !abort |=>
        st.state == CONVERT || st.done_flag)
        else $error("RC clocked conversion stopped in sleep.");

    ack_next_cycle_a: assert property (@(posedge clk) disable iff (rst)
        wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
        else $error("Bus request not answered in one cycle.");

endmodule // adc_and_temp_sense_control

/* File: shared/adc_params.svh */
// Constants for the converter control block: register offsets, field positions, resets, timing.
// Assumes a 32-bit classic Wishbone bus with byte addresses and one register per aligned word.
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH
// Notes on behaviour
// - Each conversion yields a 10-bit successive-approximation result stored in two result bytes.
// - Eleven sources: eight pins, temperature indicator, reference buffer, converter output.
// - Positive reference is pin or supply by select field; negative is always ground.
// - Clock select: 000 /2, 100 /4, 001 /8, 101 /16, 010 /32, 110 /64, x11 RC.
// - One bit period is one conversion clock period; a conversion lasts 11.5 periods.
// - Divided clocks follow the system clock; the RC choice is independent of it.
// - Conversions continue in sleep only with the RC clock; otherwise they abort.
// - The done flag sets at every conversion end, regardless of interrupt enable.
// - An enabled done interrupt during sleep wakes the device.
// - After wake, service routine runs only when global and peripheral enables are set.
// - A format bit selects left or right justification of the result pair.
// - Temperature indicator is active only while its enable bit is set.
// - Range bit set selects high range, cleared selects low range.
// - The indicator reaches the converter through its own dedicated channel.
// - Code 11101 routes the indicator, 11111 the reference buffer; unused codes connect nothing.
// - Completion clears the busy bit, sets the done flag and loads the result.
// - Right justified: upper six high bits zero; left justified: lower six low bits zero.

`define OFS_CONTROL_0 8'h00
`define OFS_CONTROL_1 8'h04
`define OFS_RESULT_HIGH 8'h08
`define OFS_RESULT_LOW 8'h0C
`define OFS_REF_SENSOR 8'h10
`define OFS_FLAG_REG_1 8'h14
`define OFS_ENABLE_REG_1 8'h18
`define OFS_IRQ_CONTROL 8'h1C

`define CH_LSB 2
`define GO_BIT 1
`define ON_BIT 0
`define JUSTIFY_BIT 7
`define CLKSEL_LSB 4
`define FVR_EN_BIT 7
`define FVR_RDY_BIT 6
`define SENSOR_EN_BIT 5
`define SENSOR_RANGE_BIT 4
`define GLOBAL_EN_BIT 7
`define PERIPH_EN_BIT 6

`define CH_TEMP 5'h1D
`define CH_DAC 5'h1E
`define CH_FIXED_REF 5'h1F
`define PREF_PIN 2'h2
`define REF_SENSOR_RESET 8'h00
`define TRIAL_START 10'h200
`define HALF_PERIODS 5'h17
`define LAST_DECIDE 5'h15

`endif

/* File: shared/adc_pkg.sv */
// Types for the converter control block: bus carriers, analog control bundle, conversion state enum.
// Assumes the constants header is included by the design file that imports this package.
package adc_pkg;

    typedef enum logic [1:0] {
        IDLE = 2'b00,
        CONVERT = 2'b01
    } conv_state_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic [4:0] channel;
        logic channel_valid;
        logic temp_route;
        logic fixed_ref_route;
        logic ref_pin_select;
        logic sample_hold;
        logic [9:0] trial_code;
        logic converter_active;
        logic temp_sensor_enable;
        logic temp_sensor_range;
        logic fixed_reference_enable;
        logic [1:0] comparator_ref_gain;
        logic [1:0] converter_ref_gain;
    } analog_ctl_t;

endpackage

/* File: verif/analog_source_model.sv */
// Analog side of the converter: pin and internal source levels, comparator, RC oscillator.
// Assumes the converter's analog control bundle and the bench clock; levels are 10-bit codes.
`timescale 1ns/100ps

module analog_source_model (
    input wire logic clk,
    input wire adc_pkg::analog_ctl_t analog_ctl,
    output logic comparator_pin,
    output logic internal_rc_conv_clock
);
    import adc_pkg::*;
    logic [9:0] level;
    logic connected;
    logic toggle = 1'b0;

    // The RC oscillator runs free, with no phase relation to clk.
    initial internal_rc_conv_clock = 1'b0;
    always #317.3 internal_rc_conv_clock = ~internal_rc_conv_clock;

    // An input that nothing drives flips every cycle so it never passes for a steady level.
    always @(posedge clk) begin
        toggle <= ~toggle;
    end

    always_comb begin
        connected = analog_ctl.converter_active;
        level = 10'h000;
        case (analog_ctl.channel)
            5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07: level = {1'b0, analog_ctl.channel[2:0], 6'h15};
            5'h1D: begin
                connected = connected & analog_ctl.temp_sensor_enable;
                level = analog_ctl.temp_sensor_range ? 10'h2A6 : 10'h359;
            end
            5'h1E: level = 10'h3FF;
            5'h1F: begin
                connected = connected & analog_ctl.fixed_reference_enable;
                level = 10'h133;
            end
            default: connected = 1'b0;
        endcase
        // Half an LSB above the code, so ties never arise against a trial word.
        comparator_pin = connected ? ({level, 1'b1} > {analog_ctl.trial_code, 1'b0}) : toggle;
    end
endmodule // analog_source_model

/* File: verif/adc_and_temp_sense_control_bench.sv */
// Self-checking bench for the converter control block, registers reached over Wishbone.
// Assumes the analog source model on the far side of the converter.
`timescale 1ns/100ps

module adc_and_temp_sense_control_bench;
    import adc_pkg::*;
    typedef struct packed {
        logic [4:0] ch;
        logic [2:0] cs;
        logic fm;
        logic [7:0] rf;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [5:0] h;
    } row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cpu_sleep = 1'b0;
    logic comparator_pin;
    logic internal_rc_conv_clock;
    wb_req_t wb_req = '0;
    wb_rsp_t wb_rsp;
    analog_ctl_t analog_ctl;
    logic wake_request;
    logic take_isr;
    int bad_count = 0;
    int checks = 0;
    int n;
    logic [31:0] rd;
    row_t r;
    row_t rows [9] = '{
        row_t'{5'h1E, 3'b000, 1'b1, 8'h00, 8'h03, 8'hFF, 6'h01},
        row_t'{5'h1E, 3'b100, 1'b0, 8'h00, 8'hFF, 8'hC0, 6'h02},
        row_t'{5'h1E, 3'b001, 1'b1, 8'h00, 8'h03, 8'hFF, 6'h04},
        row_t'{5'h00, 3'b101, 1'b1, 8'h00, 8'h00, 8'h15, 6'h08},
        row_t'{5'h03, 3'b010, 1'b0, 8'h00, 8'h35, 8'h40, 6'h10},
        row_t'{5'h07, 3'b110, 1'b1, 8'h00, 8'h01, 8'hD5, 6'h20},
        row_t'{5'h1F, 3'b101, 1'b1, 8'h81, 8'h01, 8'h33, 6'h08},
        row_t'{5'h1D, 3'b101, 1'b1, 8'h30, 8'h02, 8'hA6, 6'h08},
        row_t'{5'h1D, 3'b101, 1'b0, 8'h20, 8'hD6, 8'h40, 6'h08}};
    // Bits: irq enable, global, peripheral, expected service entry.
    logic [3:0] sl [4] = '{4'b1111, 4'b1000, 4'b1100, 4'b0110};

    always #50 clk = ~clk;

    adc_and_temp_sense_control dut (.clk(clk), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .comparator_pin(comparator_pin), .internal_rc_conv_clock(internal_rc_conv_clock),
        .cpu_sleep(cpu_sleep), .analog_ctl(analog_ctl), .wake_request(wake_request), .take_isr(take_isr));

    analog_source_model far_side (.clk(clk), .analog_ctl(analog_ctl), .comparator_pin(comparator_pin),
        .internal_rc_conv_clock(internal_rc_conv_clock));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task give_verdict;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task timeout;
        bad_count++;
        $display("[ERR] %0t wait ran out", $time);
        give_verdict();
    endtask

    task bus(input logic we, input logic [7:0] adr, input logic [7:0] d, input logic [3:0] sel);
        int k;
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, we, adr, sel, {24'h000000, d}};
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (k > 20) timeout();
        end while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat;
        wb_req <= '0;
    endtask

    task wr(input logic [7:0] adr, input logic [7:0] d);
        bus(1'b1, adr, d, 4'hF);
    endtask

    task rdr(input logic [7:0] adr);
        bus(1'b0, adr, 8'h00, 4'hF);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1;
        check(wb_rsp.ack, 0);
        check(analog_ctl, 0);
        check({wake_request, take_isr}, 0);
        for (int a = 0; a <= 32; a += 4) begin
            rdr(a[7:0]);
            check(rd, 0);
        end
        bus(1'b1, 8'h10, 8'hFF, 4'hE);
        wr(8'h20, 8'hFF);
        rdr(8'h10);
        check(rd, 0);
        rdr(8'h20);
        check(rd, 0);
        wr(8'h10, 8'hBF);
        #1;
        check({analog_ctl.temp_sensor_enable, analog_ctl.temp_sensor_range}, 2'b11);
        check(analog_ctl.fixed_reference_enable, 1);
        check({analog_ctl.comparator_ref_gain, analog_ctl.converter_ref_gain}, 4'hF);
        rdr(8'h10);
        check(rd, 8'hFF);
        wr(8'h10, 8'h10);
        #1;
        check({analog_ctl.temp_sensor_enable, analog_ctl.temp_sensor_range}, 2'b01);
        for (int i = 0; i < 9; i++) begin
            r = rows[i];
            wr(8'h10, r.rf);
            wr(8'h04, {r.fm, r.cs, 2'b00, i[0], 1'b0});
            wr(8'h00, {1'b0, r.ch, 2'b01});
            #1;
            check(analog_ctl.channel, r.ch);
            check(analog_ctl.channel_valid, 1);
            check(analog_ctl.temp_route, r.ch == 5'h1D);
            check(analog_ctl.fixed_ref_route, r.ch == 5'h1F);
            check(analog_ctl.ref_pin_select, i[0]);
            rdr(8'h04);
            check(rd, {r.fm, r.cs, 2'b00, i[0], 1'b0});
            repeat ((r.ch == 5'h1D) ? 2000 : 8) @(posedge clk);
            wr(8'h00, {1'b0, r.ch, 2'b11});
            #1;
            check({analog_ctl.trial_code, analog_ctl.sample_hold}, {10'h200, 1'b0});
            n = 1;
            while (analog_ctl.sample_hold !== 1'b1) begin
                @(posedge clk);
                #1;
                n++;
                if (n > 3000) timeout();
            end
            check(n, 23 * r.h);
            rdr(8'h14);
            check(rd, 1);
            rdr(8'h00);
            check(rd, {r.ch, 2'b01});
            rdr(8'h08);
            check(rd, r.hi);
            rdr(8'h0C);
            check(rd, r.lo);
            wr(8'h14, 8'h00);
        end
        for (int j = 0; j < 4; j++) begin
            wr(8'h18, {7'h00, sl[j][3]});
            wr(8'h1C, {sl[j][2:1], 6'h00});
            rdr(8'h1C);
            check(rd, {sl[j][2:1], 6'h00});
            wr(8'h04, {1'b1, j[0], 2'b11, 4'h0});
            wr(8'h00, 8'h7B);
            @(posedge clk);
            cpu_sleep <= 1'b1;
            @(posedge clk);
            #1;
            check(analog_ctl.converter_active, 1);
            n = 0;
            while (wake_request !== 1'b1 && n < 400) begin
                @(posedge clk);
                #1;
                n++;
            end
            check({wake_request, take_isr}, {sl[j][3], sl[j][0]});
            rdr(8'h14);
            check(rd, 1);
            cpu_sleep <= 1'b0;
            wr(8'h14, 8'h00);
        end
        wr(8'h04, 8'hD0);
        wr(8'h00, 8'h7B);
        @(posedge clk);
        cpu_sleep <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check(analog_ctl.converter_active, 0);
        repeat (200) @(posedge clk);
        rdr(8'h14);
        check(rd, 0);
        rdr(8'h0C);
        check(rd, 8'hFF);
        cpu_sleep <= 1'b0;
        wr(8'h00, 8'h1F);
        wr(8'h00, 8'h1D);
        wr(8'h00, 8'h71);
        #1;
        check({analog_ctl.channel_valid, analog_ctl.temp_route, analog_ctl.fixed_ref_route}, 0);
        rdr(8'h14);
        check(rd, 0);
        rdr(8'h0C);
        check(rd, 0);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdr(8'h00);
        check(rd, 0);
        give_verdict();
    end
endmodule // adc_and_temp_sense_control_bench
